// ---- design/psi_pc_unit.sv ----
// Program counter, return stack control and indirect address former
// Overview of operation
// - PC is 13 bits; low byte readable/writable, upper five bits not reachable.
// - Every reset clears the whole program counter.
// - Writing the PC low byte loads PC[12:8] from high latch bits 4..0.
// - Call and goto take PC[12:11] from high latch bits 4 and 3.
// - Return stack holds eight 13-bit entries, pointer hidden from software.
// - Calls and interrupt vectoring push the PC.
// - Return, return-with-literal and return-from-interrupt pop into the PC.
// - Pushes and pops never change the high latch.
// - Stack is circular; ninth push overwrites the first.
// - No overflow or underflow status and no explicit push/pop.
// - Indirect port is not storage; it accesses the pointer's target.
// - Indirect read through a pointer to the port itself returns zero.
// - Indirect write through a pointer to the port itself stores nothing.
// - Indirect address is bank bit concatenated with the 8-bit pointer.
`timescale 1ns/1ps
module psi_pc_unit
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Program counter control from execution logic
  input wire psi_pkg::psi_op_t pc_op_i,
  input wire logic [psi_pkg::JUMP_W-1:0] jump_target_i,
  input wire logic pc_low_byte_we_i,
  input wire logic [psi_pkg::LOW_BYTE_W-1:0] pc_low_byte_wdata_i,
  input wire logic pc_high_latch_we_i,
  input wire logic [psi_pkg::LOW_BYTE_W-1:0] pc_high_latch_wdata_i,
  // Indirect access request
  input wire logic ind_req_i,
  input wire logic ind_we_i,
  input wire logic [psi_pkg::SEL_W-1:0] ind_wdata_i,
  input wire logic [psi_pkg::SEL_W-1:0] file_select_pointer_i,
  input wire logic indirect_bank_bit_i,
  input wire logic [psi_pkg::SEL_W-1:0] data_rdata_i,
  // Program counter outputs
  output logic [psi_pkg::PC_W-1:0] pc_o,
  output logic [psi_pkg::LOW_BYTE_W-1:0] pc_low_byte_o,
  output logic [psi_pkg::PC_HIGH_W-1:0] pc_high_latch_o,
  // Indirect data access
  output logic [psi_pkg::IADDR_W-1:0] data_addr_o,
  output logic data_we_o,
  output logic [psi_pkg::SEL_W-1:0] data_wdata_o,
  output logic [psi_pkg::SEL_W-1:0] ind_rdata_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [psi_pkg::PC_W-1:0] pc_reg;
  logic [psi_pkg::PC_W-1:0] pc_next;
  logic [psi_pkg::PC_HIGH_W-1:0] latch_reg;
  logic [psi_pkg::IADDR_W-1:0] daddr_reg;
  logic dwe_reg;
  logic [psi_pkg::SEL_W-1:0] dwdata_reg;
  logic [psi_pkg::SEL_W-1:0] rdata_reg;
  logic self_sel;
  psi_stack_if sif ();

  psi_return_stack #(
    .DEPTH(psi_pkg::STACK_DEPTH)
  ) u_stack (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Push and pop come only from call, interrupt and return operations
  assign sif.push = (pc_op_i == psi_pkg::PSI_OP_CALL) ||
                    (pc_op_i == psi_pkg::PSI_OP_IRQ);
  assign sif.pop = (pc_op_i == psi_pkg::PSI_OP_RET);
  // Return address is the next instruction
  assign sif.push_data = pc_reg + 13'h0001;

  // High latch is only written by software, never by stack traffic
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      latch_reg <= 5'h00;
    else if (pc_high_latch_we_i)
      latch_reg <= pc_high_latch_wdata_i[psi_pkg::PC_HIGH_W-1:0];
  end

  // A low-byte write wins over sequencing; the write is the jump itself
  always_comb
  begin
    pc_next = pc_reg + 13'h0001;
    if (pc_low_byte_we_i)
      pc_next = {latch_reg, pc_low_byte_wdata_i};
    else
    begin
      case (pc_op_i)
        psi_pkg::PSI_OP_HOLD: pc_next = pc_reg;
        psi_pkg::PSI_OP_JUMP,
        psi_pkg::PSI_OP_CALL: pc_next = {latch_reg[4:3], jump_target_i};
        psi_pkg::PSI_OP_RET: pc_next = sif.top_data;
        psi_pkg::PSI_OP_IRQ: pc_next = psi_pkg::IRQ_VECTOR;
        default: pc_next = pc_reg + 13'h0001;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      pc_reg <= psi_pkg::PC_RESET;
    else
      pc_reg <= pc_next;
  end

  assign pc_o = pc_reg;
  assign pc_low_byte_o = pc_reg[7:0];
  assign pc_high_latch_o = latch_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Indirect port: registered address/strobe, one cycle after the request
  assign self_sel = (file_select_pointer_i == psi_pkg::INDIRECT_ADDR);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      daddr_reg <= 9'h000;
      dwe_reg <= 1'b0;
      dwdata_reg <= psi_pkg::DATA_RESET;
    end
    else
    begin
      daddr_reg <= {indirect_bank_bit_i, file_select_pointer_i};
      dwe_reg <= ind_req_i && ind_we_i && !self_sel;
      dwdata_reg <= ind_wdata_i;
    end
  end

  // Read data: memory data, or zero when pointing at the port itself
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rdata_reg <= psi_pkg::READ_ZERO;
    else if (ind_req_i && !ind_we_i)
      rdata_reg <= self_sel ? psi_pkg::READ_ZERO : data_rdata_i;
  end

  assign data_addr_o = daddr_reg;
  assign data_we_o = dwe_reg;
  assign data_wdata_o = dwdata_reg;
  assign ind_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_reset_clear;
    @(posedge clk_sys_i) !rst_n_i |=> pc_o == 13'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("pc not cleared");

  property p_low_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      pc_low_byte_we_i |=> pc_o == {$past(latch_reg), $past(pc_low_byte_wdata_i)};
  endproperty
  a_low_write: assert property (p_low_write) else $error("low write load wrong");

  property p_call_goto;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!pc_low_byte_we_i && (pc_op_i == psi_pkg::PSI_OP_JUMP || pc_op_i == psi_pkg::PSI_OP_CALL))
      |=> pc_o == {$past(latch_reg[4:3]), $past(jump_target_i)};
  endproperty
  a_call_goto: assert property (p_call_goto) else $error("jump load wrong");

  property p_call_return;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (pc_op_i == psi_pkg::PSI_OP_CALL && !pc_low_byte_we_i) ##1
      (pc_op_i == psi_pkg::PSI_OP_RET && !pc_low_byte_we_i) |=> pc_o == $past(pc_o, 2) + 13'h0001;
  endproperty
  a_call_return: assert property (p_call_return) else $error("return address wrong");

  property p_latch_stable;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !pc_high_latch_we_i |=> $stable(pc_high_latch_o);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("latch changed");

  property p_self_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ind_req_i && self_sel) |=> !data_we_o;
  endproperty
  a_self_write: assert property (p_self_write) else $error("self write stored");

  property p_self_read;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ind_req_i && !ind_we_i && self_sel) |=> ind_rdata_o == 8'h00;
  endproperty
  a_self_read: assert property (p_self_read) else $error("self read nonzero");

  property p_addr_form;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      ind_req_i |=> data_addr_o == {$past(indirect_bank_bit_i), $past(file_select_pointer_i)};
  endproperty
  a_addr_form: assert property (p_addr_form) else $error("indirect address wrong");

  property p_irq_vector;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (pc_op_i == psi_pkg::PSI_OP_IRQ && !pc_low_byte_we_i) |=> pc_o == 13'h0004;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("vector wrong");

  property p_step;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (pc_op_i == psi_pkg::PSI_OP_STEP && !pc_low_byte_we_i)
      |=> pc_o == $past(pc_o) + 13'h0001;
  endproperty
  a_step: assert property (p_step) else $error("step wrong");

  // Only bits 4..0 of a latch write are kept; they feed every later low-byte write
  property p_latch_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      pc_high_latch_we_i |=>
      pc_high_latch_o == $past(pc_high_latch_wdata_i[psi_pkg::PC_HIGH_W-1:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost");

  c_call: cover property (@(posedge clk_sys_i) pc_op_i == psi_pkg::PSI_OP_CALL);
  c_irq: cover property (@(posedge clk_sys_i) pc_op_i == psi_pkg::PSI_OP_IRQ);
  c_ret: cover property (@(posedge clk_sys_i) pc_op_i == psi_pkg::PSI_OP_RET);
  c_low: cover property (@(posedge clk_sys_i) pc_low_byte_we_i);
  c_ind_wr: cover property (@(posedge clk_sys_i) data_we_o);
endmodule

// ---- design/psi_pkg.sv ----
// Shared constants and types for the program counter, return stack and indirect unit
package psi_pkg;
  localparam int PC_W = 13;
  localparam int LOW_BYTE_W = 8;
  localparam int PC_HIGH_W = 5;
  localparam int JUMP_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int SEL_W = 8;
  localparam int IADDR_W = 9;
  // Data address at which the indirect port is decoded
  localparam logic [7:0] INDIRECT_ADDR = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [SEL_W-1:0] DATA_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Interrupt vector address
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  // Execution operations on the program counter
  typedef enum logic [2:0]
  {
    PSI_OP_STEP,
    PSI_OP_HOLD,
    PSI_OP_JUMP,
    PSI_OP_CALL,
    PSI_OP_RET,
    PSI_OP_IRQ
  } psi_op_t;
endpackage

// ---- design/psi_return_stack.sv ----
// Eight-entry circular return stack with hidden pointer
`timescale 1ns/1ps
module psi_return_stack #(
  parameter int DEPTH = psi_pkg::STACK_DEPTH
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Push and pop
  psi_stack_if.stack sif
);
  logic [psi_pkg::PC_W-1:0] mem_reg [DEPTH];
  logic [psi_pkg::SP_W-1:0] sp_reg;

  // Pointer is never exposed; it wraps both ways with no over/underflow flag
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      sp_reg <= psi_pkg::SP_RESET;
    else if (sif.push)
      sp_reg <= sp_reg + 3'h1;
    else if (sif.pop)
      sp_reg <= sp_reg - 3'h1;
  end

  // Entries are not reset; a pop below the oldest entry returns stale data
  always_ff @(posedge clk_sys_i)
  begin
    if (sif.push)
      mem_reg[sp_reg] <= sif.push_data;
  end

  assign sif.top_data = mem_reg[sp_reg - 3'h1];
endmodule

// ---- design/psi_stack_if.sv ----
// Push/pop carrier between the unit and its return stack
`timescale 1ns/1ps
interface psi_stack_if;
  logic push;
  logic pop;
  logic [psi_pkg::PC_W-1:0] push_data;
  logic [psi_pkg::PC_W-1:0] top_data;
  modport owner (output push, output pop, output push_data, input top_data);
  modport stack (input push, input pop, input push_data, output top_data);
endinterface

// ---- dv/psi_data_mem.sv ----
// Data memory model standing behind the unit's indirect accesses
`timescale 1ns/1ps
module psi_data_mem
(
  // Clock
  input wire logic clk_sys_i,
  // Access
  input wire logic [psi_pkg::IADDR_W-1:0] rd_addr_i,
  input wire logic [psi_pkg::IADDR_W-1:0] wr_addr_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:511];
  // Preset with a pattern so a zero read of the port itself cannot pass by luck
  initial
  begin
    for (int a = 0; a < 512; a++)
      mem[a] = a[7:0] ^ 8'h5a;
  end
  always @(posedge clk_sys_i)
  begin
    if (we_i)
      mem[wr_addr_i] <= wdata_i;
  end
  assign rdata_o = mem[rd_addr_i];
endmodule

// ---- dv/psi_pc_unit_tb.sv ----
// Self-checking bench for the program counter, return stack and indirect unit
`timescale 1ns/1ps
module psi_pc_unit_tb;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  psi_pkg::psi_op_t op = psi_pkg::PSI_OP_HOLD;
  logic [10:0] tgt = 11'h000;
  logic low_we = 1'h0, lat_we = 1'h0, ind_req = 1'h0, ind_we = 1'h0, bank = 1'h0;
  logic [7:0] low_d = 8'h00, lat_d = 8'h00, ind_d = 8'h00, sel_ptr = 8'h00;
  logic [7:0] rdata, low_o, ind_rd, dwd;
  logic [12:0] pc;
  logic [4:0] lat_o;
  logic [8:0] daddr;
  logic dwe;
  int fail_count = 0;
  int n_tests = 0;
  logic [12:0] pushed [0:8];
  psi_pc_unit psi_pc_unit_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pc_op_i(op),
    .jump_target_i(tgt), .pc_low_byte_we_i(low_we), .pc_low_byte_wdata_i(low_d),
    .pc_high_latch_we_i(lat_we), .pc_high_latch_wdata_i(lat_d), .ind_req_i(ind_req),
    .ind_we_i(ind_we), .ind_wdata_i(ind_d), .file_select_pointer_i(sel_ptr),
    .indirect_bank_bit_i(bank), .data_rdata_i(rdata), .pc_o(pc), .pc_low_byte_o(low_o),
    .pc_high_latch_o(lat_o), .data_addr_o(daddr), .data_we_o(dwe), .data_wdata_o(dwd),
    .ind_rdata_o(ind_rd));
  psi_data_mem psi_data_mem_i (.clk_sys_i(clk_sys_i), .rd_addr_i({bank, sel_ptr}),
    .wr_addr_i(daddr), .we_i(dwe), .wdata_i(dwd), .rdata_o(rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One instruction cycle from falling edge to falling edge; s is {low, latch, indirect}.
  // Strobes are set once per call so no signal is driven twice in one time step
  task automatic cyc(input psi_pkg::psi_op_t o, input logic [10:0] t, input logic [2:0] s);
    op = o;
    tgt = t;
    low_we = s[2];
    lat_we = s[1];
    ind_req = s[0];
    @(negedge clk_sys_i);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    #200_000;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    repeat (10) @(negedge clk_sys_i);
    chk(pc, 13'h0000);
    rst_n_i = 1'h1;
    cyc(psi_pkg::PSI_OP_STEP, 11'h000, 3'b000);
    chk(pc, 13'h0001);
    lat_d = 8'hff;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b010);
    chk(lat_o, 5'h1f);
    low_d = 8'h34;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b100);
    chk(pc, 13'h1f34);
    chk(low_o, 8'h34);
    cyc(psi_pkg::PSI_OP_JUMP, 11'h555, 3'b000);
    chk(pc, 13'h1d55);
    // Nine nested calls: the ninth push lands on the first slot
    for (int i = 0; i < 9; i++)
    begin
      pushed[i] = pc + 13'h0001;
      cyc(psi_pkg::PSI_OP_CALL, 11'(i * 100 + 7), 3'b000);
      chk(pc, {2'h3, 11'(i * 100 + 7)});
    end
    for (int i = 8; i >= 0; i--)
    begin
      cyc(psi_pkg::PSI_OP_RET, 11'h000, 3'b000);
      chk(pc, pushed[i == 0 ? 8 : i]);
    end
    chk(lat_o, 5'h1f);
    pushed[0] = pc + 13'h0001;
    cyc(psi_pkg::PSI_OP_IRQ, 11'h000, 3'b000);
    chk(pc, psi_pkg::IRQ_VECTOR);
    cyc(psi_pkg::PSI_OP_RET, 11'h000, 3'b000);
    chk(pc, pushed[0]);
    lat_d = 8'he2;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b010);
    low_d = 8'hff;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b100);
    chk(pc, 13'h02ff);
    // Computed jump across a low-byte wrap: software bumps the latch itself
    low_d = 8'h01;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b100);
    chk(pc, 13'h0201);
    chk(lat_o, 5'h02);
    lat_d = 8'h03;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b010);
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b100);
    chk(pc, 13'h0301);
    sel_ptr = 8'h20;
    bank = 1'h1;
    ind_d = 8'ha5;
    ind_we = 1'h1;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b001);
    chk(daddr, 9'h120);
    chk({dwe, dwd}, 9'h1a5);
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b000);
    chk(dwe, 1'h0);
    ind_we = 1'h0;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b001);
    chk(ind_rd, 8'ha5);
    bank = 1'h0;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b001);
    chk(ind_rd, 8'h7a);
    sel_ptr = 8'h00;
    ind_we = 1'h1;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b001);
    chk(dwe, 1'h0);
    ind_we = 1'h0;
    cyc(psi_pkg::PSI_OP_HOLD, 11'h000, 3'b001);
    chk(ind_rd, 8'h00);
    rst_n_i = 1'h0;
    cyc(psi_pkg::PSI_OP_STEP, 11'h000, 3'b000);
    chk(pc, 13'h0000);
    chk(lat_o, 5'h00);
    // Release in mid-run: the first request lands on the first edge after it
    rst_n_i = 1'h1;
    cyc(psi_pkg::PSI_OP_STEP, 11'h000, 3'b000);
    chk(pc, 13'h0001);
    cyc(psi_pkg::PSI_OP_CALL, 11'h010, 3'b000);
    chk(pc, 13'h0010);
    cyc(psi_pkg::PSI_OP_RET, 11'h000, 3'b000);
    chk(pc, 13'h0002);
    wrap_up();
  end
endmodule
